/* File: verilog/sfr_page_select_stack.sv */
`timescale 1ns/1ns
module sfr_page_select_stack (
  input  wire logic       CLK,
  input  wire logic       RESET,
  input  wire logic [7:0] SFR_ADDR,
  input  wire logic [7:0] SFR_WDATA,
  input  wire logic       SFR_WR,
  input  wire logic       SFR_RD,
  output logic      [7:0] SFR_RDATA,
  output logic            SFR_HIT,
  input  wire logic       INT_ENTRY,
  input  wire logic [7:0] INT_PAGE,
  input  wire logic       INT_RETURN,
  output logic      [7:0] ACTIVE_PAGE,
  output logic      [4:0] PAGE_SEL,
  output logic            PAGE_VALID,
  output logic            AUTO_PAGE_EN
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  // Maps a page number onto the one-hot select of implemented pages.
  function automatic logic [sfr_page_pkg::NUM_PAGES-1:0] page_onehot(input logic [7:0] page);
    logic [sfr_page_pkg::NUM_PAGES-1:0] sel;
    sel = '0;
    sel[sfr_page_pkg::SEL_PAGE_0] = (page == sfr_page_pkg::PAGE_0);
    sel[sfr_page_pkg::SEL_PAGE_1] = (page == sfr_page_pkg::PAGE_1);
    sel[sfr_page_pkg::SEL_PAGE_2] = (page == sfr_page_pkg::PAGE_2);
    sel[sfr_page_pkg::SEL_PAGE_3] = (page == sfr_page_pkg::PAGE_3);
    sel[sfr_page_pkg::SEL_PAGE_F] = (page == sfr_page_pkg::PAGE_F);
    return sel;
  endfunction

  // True when an address belongs to one of this block's registers.
  function automatic logic is_own_addr(input logic [7:0] addr);
    return (addr == sfr_page_pkg::ADDR_PAGE_CONTROL) || (addr == sfr_page_pkg::ADDR_ACTIVE_PAGE) ||
           (addr == sfr_page_pkg::ADDR_STACK_MIDDLE) || (addr == sfr_page_pkg::ADDR_STACK_BOTTOM);
  endfunction

  // ----------------------------------------------------------------
  // Internal signals
  // ----------------------------------------------------------------
  logic       auto_en_q;
  logic [7:0] rdata_q;
  logic       hit_q;
  logic       wr_ctrl;

  page_stack_if st ();

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  // Addresses are compared without regard to the active page, so all
  // four registers are reachable from every page.
  assign wr_ctrl   = SFR_WR && (SFR_ADDR == sfr_page_pkg::ADDR_PAGE_CONTROL);
  assign st.wr_top = SFR_WR && (SFR_ADDR == sfr_page_pkg::ADDR_ACTIVE_PAGE);
  assign st.wr_mid = SFR_WR && (SFR_ADDR == sfr_page_pkg::ADDR_STACK_MIDDLE);
  assign st.wr_bot = SFR_WR && (SFR_ADDR == sfr_page_pkg::ADDR_STACK_BOTTOM);
  assign st.wdata  = SFR_WDATA;

  // ----------------------------------------------------------------
  // Stack control
  // ----------------------------------------------------------------
  // Disabling auto-paging stops both the page switch and the stack, so an
  // entry with the enable clear leaves all three entries alone. Entry wins
  // if the core ever raises entry and return together.
  assign st.push      = INT_ENTRY && auto_en_q;
  assign st.pop       = INT_RETURN && auto_en_q && !INT_ENTRY;
  assign st.push_page = INT_PAGE;

  page_stack u_stack (
    .clk   (CLK),
    .reset (RESET),
    .st    (st.stack)
  );

  // ----------------------------------------------------------------
  // Page control register
  // ----------------------------------------------------------------
  // Only bit 0 is stored; the reserved bits are dropped on write.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      auto_en_q <= sfr_page_pkg::AUTO_EN_RESET;
    end else if (wr_ctrl) begin
      auto_en_q <= SFR_WDATA[sfr_page_pkg::AUTO_EN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Read data is registered and valid in the cycle after the read strobe;
  // foreign addresses answer zero with the hit flag low.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      rdata_q <= sfr_page_pkg::UNMAPPED_READ;
      hit_q   <= 1'b0;
    end else if (SFR_RD) begin
      hit_q <= is_own_addr(SFR_ADDR);
      unique case (SFR_ADDR)
        sfr_page_pkg::ADDR_PAGE_CONTROL: rdata_q <= {sfr_page_pkg::RESERVED_READ, auto_en_q};
        sfr_page_pkg::ADDR_ACTIVE_PAGE:  rdata_q <= st.top;
        sfr_page_pkg::ADDR_STACK_MIDDLE: rdata_q <= st.mid;
        sfr_page_pkg::ADDR_STACK_BOTTOM: rdata_q <= st.bot;
        default:                         rdata_q <= sfr_page_pkg::UNMAPPED_READ;
      endcase
    end else begin
      hit_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // The page select steers the decode of every paged register outside.
  assign ACTIVE_PAGE  = st.top;
  assign PAGE_SEL     = page_onehot(st.top);
  assign PAGE_VALID   = |page_onehot(st.top);
  assign AUTO_PAGE_EN = auto_en_q;
  assign SFR_RDATA    = rdata_q;
  assign SFR_HIT      = hit_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_push_req;
    INT_ENTRY && auto_en_q;
  endsequence

  sequence s_pop_req;
    INT_RETURN && auto_en_q && !INT_ENTRY;
  endsequence

  property p_ctrl_read;
    @(posedge CLK) disable iff (RESET)
      (SFR_RD && SFR_ADDR == sfr_page_pkg::ADDR_PAGE_CONTROL) |=>
        (SFR_RDATA == {7'h00, $past(auto_en_q)}) && SFR_HIT;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("page control read wrong");

  property p_top_read;
    @(posedge CLK) disable iff (RESET)
      (SFR_RD && SFR_ADDR == sfr_page_pkg::ADDR_ACTIVE_PAGE) |=> (SFR_RDATA == $past(st.top)) && SFR_HIT;
  endproperty
  a_top_read: assert property (p_top_read) else $error("active page read wrong");

  property p_entry_load;
    @(posedge CLK) disable iff (RESET)
      s_push_req |=> (ACTIVE_PAGE == $past(INT_PAGE));
  endproperty
  a_entry_load: assert property (p_entry_load) else $error("entry did not load source page");

  property p_entry_hold;
    @(posedge CLK) disable iff (RESET)
      (INT_ENTRY && !auto_en_q && !SFR_WR) |=> $stable(ACTIVE_PAGE) && $stable(st.mid) && $stable(st.bot);
  endproperty
  a_entry_hold: assert property (p_entry_hold) else $error("page changed with auto-page off");

  property p_top_write;
    @(posedge CLK) disable iff (RESET)
      (st.wr_top && !INT_ENTRY && !INT_RETURN) |=> (ACTIVE_PAGE == $past(SFR_WDATA));
  endproperty
  a_top_write: assert property (p_top_write) else $error("active page write lost");

  property p_push_shift;
    @(posedge CLK) disable iff (RESET)
      s_push_req |=> (st.mid == $past(st.top)) && (st.bot == $past(st.mid));
  endproperty
  a_push_shift: assert property (p_push_shift) else $error("push did not shift stack");

  property p_pop_shift;
    @(posedge CLK) disable iff (RESET)
      s_pop_req |=> (ACTIVE_PAGE == $past(st.mid)) && (st.mid == $past(st.bot)) && (st.bot == 8'h00);
  endproperty
  a_pop_shift: assert property (p_pop_shift) else $error("pop did not restore stack");

  property p_mid_write_only;
    @(posedge CLK) disable iff (RESET)
      (st.wr_mid && !INT_ENTRY && !INT_RETURN) |=>
        $stable(ACTIVE_PAGE) && $stable(st.bot) && (st.mid == $past(SFR_WDATA));
  endproperty
  a_mid_write_only: assert property (p_mid_write_only) else $error("middle write disturbed stack");

  property p_no_event_stable;
    @(posedge CLK) disable iff (RESET)
      (!INT_ENTRY && !INT_RETURN && !SFR_WR) |=> $stable(ACTIVE_PAGE) && $stable(st.mid) && $stable(st.bot);
  endproperty
  a_no_event_stable: assert property (p_no_event_stable) else $error("stack moved without cause");

  property p_mid_read;
    @(posedge CLK) disable iff (RESET)
      (SFR_RD && SFR_ADDR == sfr_page_pkg::ADDR_STACK_MIDDLE) |=> (SFR_RDATA == $past(st.mid));
  endproperty
  a_mid_read: assert property (p_mid_read) else $error("middle entry read wrong");

  property p_bot_write;
    @(posedge CLK) disable iff (RESET)
      (st.wr_bot && !INT_ENTRY && !INT_RETURN) |=>
        (st.bot == $past(SFR_WDATA)) && $stable(ACTIVE_PAGE) && $stable(st.mid);
  endproperty
  a_bot_write: assert property (p_bot_write) else $error("bottom write lost or stack disturbed");

  property p_bot_read;
    @(posedge CLK) disable iff (RESET)
      (SFR_RD && SFR_ADDR == sfr_page_pkg::ADDR_STACK_BOTTOM) |=> (SFR_RDATA == $past(st.bot)) && SFR_HIT;
  endproperty
  a_bot_read: assert property (p_bot_read) else $error("bottom entry read wrong");

  property p_page_f_sel;
    @(posedge CLK) disable iff (RESET)
      (ACTIVE_PAGE == 8'h0f) |-> PAGE_SEL[4] && PAGE_VALID;
  endproperty
  a_page_f_sel: assert property (p_page_f_sel) else $error("page F not selected");

  property p_hit_foreign;
    @(posedge CLK) disable iff (RESET)
      (SFR_RD && SFR_ADDR == 8'h80) |=> !SFR_HIT && (SFR_RDATA == 8'h00);
  endproperty
  a_hit_foreign: assert property (p_hit_foreign) else $error("foreign address answered");

endmodule

/* File: shared/sfr_page_pkg.sv */
package sfr_page_pkg;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int          PAGE_W        = 8;
  localparam int          NUM_PAGES     = 5;
  localparam logic [7:0]  PAGE_RESET    = 8'h00;
  localparam logic        AUTO_EN_RESET = 1'b1;
  localparam int          AUTO_EN_BIT   = 0;
  localparam logic [6:0]  RESERVED_READ = 7'h00;
  localparam logic [7:0]  UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------
  // Special register addresses, all decoded on every page
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_PAGE_CONTROL = 8'h81;
  localparam logic [7:0]  ADDR_ACTIVE_PAGE  = 8'h84;
  localparam logic [7:0]  ADDR_STACK_MIDDLE = 8'h85;
  localparam logic [7:0]  ADDR_STACK_BOTTOM = 8'h86;

  // ----------------------------------------------------------------
  // Implemented page numbers
  // ----------------------------------------------------------------
  localparam logic [7:0]  PAGE_0 = 8'h00;
  localparam logic [7:0]  PAGE_1 = 8'h01;
  localparam logic [7:0]  PAGE_2 = 8'h02;
  localparam logic [7:0]  PAGE_3 = 8'h03;
  localparam logic [7:0]  PAGE_F = 8'h0f;

  // Index of each page in the one-hot page select.
  localparam int SEL_PAGE_0 = 0;
  localparam int SEL_PAGE_1 = 1;
  localparam int SEL_PAGE_2 = 2;
  localparam int SEL_PAGE_3 = 3;
  localparam int SEL_PAGE_F = 4;

endpackage

/* File: shared/page_stack_if.sv */
`timescale 1ns/1ns
interface page_stack_if;
  logic                            push;
  logic                            pop;
  logic [sfr_page_pkg::PAGE_W-1:0] push_page;
  logic                            wr_top;
  logic                            wr_mid;
  logic                            wr_bot;
  logic [sfr_page_pkg::PAGE_W-1:0] wdata;
  logic [sfr_page_pkg::PAGE_W-1:0] top;
  logic [sfr_page_pkg::PAGE_W-1:0] mid;
  logic [sfr_page_pkg::PAGE_W-1:0] bot;

  modport ctrl  (output push, pop, push_page, wr_top, wr_mid, wr_bot, wdata, input top, mid, bot);
  modport stack (input push, pop, push_page, wr_top, wr_mid, wr_bot, wdata, output top, mid, bot);
endinterface

/* File: verilog/page_stack.sv */
`timescale 1ns/1ns
module page_stack (
  input wire logic  clk,
  input wire logic  reset,
  page_stack_if.stack st
);

  // ----------------------------------------------------------------
  // Top entry: the page in use
  // ----------------------------------------------------------------
  // Push loads the source page, pop restores the middle entry; a push or
  // pop wins over a software write landing in the same cycle.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st.top <= sfr_page_pkg::PAGE_RESET;
    end else if (st.push) begin
      st.top <= st.push_page;
    end else if (st.pop) begin
      st.top <= st.mid;
    end else if (st.wr_top) begin
      st.top <= st.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Middle entry
  // ----------------------------------------------------------------
  // Takes the old top on push and the bottom on pop.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st.mid <= sfr_page_pkg::PAGE_RESET;
    end else if (st.push) begin
      st.mid <= st.top;
    end else if (st.pop) begin
      st.mid <= st.bot;
    end else if (st.wr_mid) begin
      st.mid <= st.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Bottom entry
  // ----------------------------------------------------------------
  // Takes the old middle on push and empties to the reset page on pop.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st.bot <= sfr_page_pkg::PAGE_RESET;
    end else if (st.push) begin
      st.bot <= st.mid;
    end else if (st.pop) begin
      st.bot <= sfr_page_pkg::PAGE_RESET;
    end else if (st.wr_bot) begin
      st.bot <= st.wdata;
    end
  end

endmodule

/* File: test/int_ctrl_model.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Core and interrupt controller stand-in
// ----------------------------------------------------------------
module int_ctrl_model (
  input  wire logic       clk,
  output logic            int_entry,
  output logic      [7:0] int_page,
  output logic            int_return
);
  // Fixed lookup from interrupt source number to the page of its registers.
  function automatic logic [7:0] src_page(input int src);
    case (src)
      0:       return 8'h00;
      1:       return 8'h01;
      2:       return 8'h02;
      3:       return 8'h03;
      default: return 8'h0f;
    endcase
  endfunction

  // Strobes rest low and the page bus starts at a defined value.
  initial begin
    int_entry  = 1'b0;
    int_return = 1'b0;
    int_page   = 8'h00;
  end

  // One-cycle entry pulse carrying the source page; the bus then carries the complement of that page.
  task automatic enter(input int src);
    @(posedge clk);
    int_entry <= 1'b1;
    int_page  <= src_page(src);
    @(posedge clk);
    int_entry <= 1'b0;
    int_page  <= ~src_page(src);
  endtask

  // Entry and return raised together; the block must treat this as an entry.
  task automatic enter_and_leave(input int src);
    @(posedge clk);
    int_entry  <= 1'b1;
    int_return <= 1'b1;
    int_page   <= src_page(src);
    @(posedge clk);
    int_entry  <= 1'b0;
    int_return <= 1'b0;
    int_page   <= ~src_page(src);
  endtask

  // One-cycle return pulse.
  task automatic leave();
    @(posedge clk);
    int_return <= 1'b1;
    @(posedge clk);
    int_return <= 1'b0;
  endtask
endmodule

/* File: test/tb_top.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Testbench for the page select and page stack
// ----------------------------------------------------------------
module tb_top;
  typedef struct {logic [7:0] addr; logic [7:0] wdata; logic [7:0] rd; logic hit; logic [7:0] act;} row_t;

  logic       CLK = 1'b0;
  logic       RESET = 1'b1;
  logic [7:0] SFR_ADDR = 8'h00;
  logic [7:0] SFR_WDATA = 8'h00;
  logic       SFR_WR = 1'b0;
  logic       SFR_RD = 1'b0;
  logic [7:0] SFR_RDATA;
  logic       SFR_HIT;
  logic       INT_ENTRY;
  logic [7:0] INT_PAGE;
  logic       INT_RETURN;
  logic [7:0] ACTIVE_PAGE;
  logic [4:0] PAGE_SEL;
  logic       PAGE_VALID;
  logic       AUTO_PAGE_EN;
  int         n_errors = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  logic [7:0] d;
  logic       h;
  row_t       rows [7];
  logic [7:0] pg [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0f, 8'h04};
  logic [4:0] sel [6] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h00};

  // Clock at 125 MHz.
  always #4 CLK = ~CLK;

  sfr_page_select_stack u_dut (.CLK(CLK), .RESET(RESET), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA),
    .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA), .SFR_HIT(SFR_HIT), .INT_ENTRY(INT_ENTRY),
    .INT_PAGE(INT_PAGE), .INT_RETURN(INT_RETURN), .ACTIVE_PAGE(ACTIVE_PAGE), .PAGE_SEL(PAGE_SEL),
    .PAGE_VALID(PAGE_VALID), .AUTO_PAGE_EN(AUTO_PAGE_EN));

  int_ctrl_model u_core (.clk(CLK), .int_entry(INT_ENTRY), .int_page(INT_PAGE), .int_return(INT_RETURN));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Prints the counts and the verdict, then stops the run.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Compares one value and reports a difference.
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One write strobe.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge CLK);
    SFR_WR    <= 1'b1;
    SFR_ADDR  <= a;
    SFR_WDATA <= v;
    @(posedge CLK);
    SFR_WR <= 1'b0;
  endtask

  // One read strobe; data and hit are taken one cycle after it.
  task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic hv);
    @(posedge CLK);
    SFR_RD   <= 1'b1;
    SFR_ADDR <= a;
    @(posedge CLK);
    SFR_RD <= 1'b0;
    #1;
    v  = SFR_RDATA;
    hv = SFR_HIT;
  endtask

  // Checks all three stack entries.
  task automatic chk_stack(input logic [7:0] t, input logic [7:0] m, input logic [7:0] b);
    #1;
    chk("top", t, ACTIVE_PAGE);
    rd(8'h85, d, h);
    chk("middle", m, d);
    rd(8'h86, d, h);
    chk("bottom", b, d);
  endtask

  // Checks the values that reset must give.
  task automatic chk_reset();
    chk("auto enable", 8'h01, {7'h00, AUTO_PAGE_EN});
    chk("page select", 8'h01, {3'h0, PAGE_SEL});
    chk_stack(8'h00, 8'h00, 8'h00);
    rd(8'h81, d, h);
    chk("control", 8'h01, d);
  endtask

  // Cuts a hang short.
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rows[0] = '{8'h84, 8'h02, 8'h02, 1'b1, 8'h02};
    rows[1] = '{8'h85, 8'h5a, 8'h5a, 1'b1, 8'h02};
    rows[2] = '{8'h86, 8'ha5, 8'ha5, 1'b1, 8'h02};
    rows[3] = '{8'h81, 8'hfe, 8'h00, 1'b1, 8'h02};
    rows[4] = '{8'h81, 8'h01, 8'h01, 1'b1, 8'h02};
    rows[5] = '{8'h80, 8'h33, 8'h00, 1'b0, 8'h02};
    rows[6] = '{8'h84, 8'h0f, 8'h0f, 1'b1, 8'h0f};
    repeat (2) @(posedge CLK);
    RESET <= 1'b0;
    chk_reset();
    // Writes and read-backs, with stack writes made while page 2 is selected.
    for (int i = 0; i < 7; i++) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, d, h);
      chk("read data", rows[i].rd, d);
      chk("hit", {7'h00, rows[i].hit}, {7'h00, h});
      chk("top after write", rows[i].act, ACTIVE_PAGE);
    end
    // Nested interrupts push twice, then two returns unwind.
    u_core.enter(2);
    chk_stack(8'h02, 8'h0f, 8'h5a);
    u_core.enter(0);
    chk_stack(8'h00, 8'h02, 8'h0f);
    u_core.leave();
    chk_stack(8'h02, 8'h0f, 8'h00);
    u_core.leave();
    chk_stack(8'h0f, 8'h00, 8'h00);
    // Every implemented page and one that is not.
    for (int i = 0; i < 6; i++) begin
      wr(8'h84, pg[i]);
      #1;
      chk("page select", {3'h0, sel[i]}, {3'h0, PAGE_SEL});
      chk("page valid", {7'h00, i < 5}, {7'h00, PAGE_VALID});
    end
    // With switching off, entry and return leave the stack alone.
    wr(8'h84, 8'h03);
    wr(8'h81, 8'h00);
    #1;
    chk("auto enable", 8'h00, {7'h00, AUTO_PAGE_EN});
    u_core.enter(4);
    chk_stack(8'h03, 8'h00, 8'h00);
    u_core.leave();
    chk_stack(8'h03, 8'h00, 8'h00);
    // Entry and return in one cycle push once, and a later return unwinds it.
    wr(8'h81, 8'h01);
    u_core.enter_and_leave(1);
    chk_stack(8'h01, 8'h03, 8'h00);
    u_core.leave();
    chk_stack(8'h03, 8'h00, 8'h00);
    // A second reset in mid-run restores every value, the enable included.
    wr(8'h81, 8'h00);
    wr(8'h85, 8'h0f);
    @(posedge CLK);
    RESET <= 1'b1;
    repeat (2) @(posedge CLK);
    RESET <= 1'b0;
    chk_reset();
    complete_run();
  end
endmodule
